// *** hdl/lepw_engine.sv ***
// Purpose: Decoder and executor for set-PWM, wait and map table setup words of the LED engines.
// Assumes: Program memory presents one word per engine with valid/ready; mapping rows come from SRAM.
// Notes:   Registers sit on a classic Wishbone slave; every access is answered one cycle after the strobe.
//
// How it works
// - Immediate set-PWM loads its 8-bit operand straight into the engine PWM value.
// - Any set-PWM occupies the engine for sixteen master clock ticks.
// - Output duty cycle is linear in the value, 0 is off, 255 is on.
// - Variable set-PWM selects A, B, C, or D (register or test ADC).
// - During wait the engine holds its PWM value unchanged.
// - Wait prescale bit picks sixteen or five hundred twelve master ticks per step.
// - Wait length is the 5-bit time field times the chosen step, a time field of 0 counting as 1.
// - Any engine may drive any driver or the general output, several at once.
// - Mapping rows read from shared SRAM decide which engine drives each output.
// - Map start word stores a 7-bit address from 0 to 95.
// - Map end word stores a 7-bit address from 0 to 95.
// - Map start word only records the address, mapping stays unchanged.
// - Variable D is read and written by the host at index 3C.
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module lepw_engine
	import lepw_pkg::*;
#(
	parameter int unsigned N_ENG    = 3,
	parameter int unsigned TICK_DIV = MASTER_DIV
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [8:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic [N_ENG-1:0]  instr_valid,
	input  wire logic [WORD_W-1:0] instr_data [N_ENG],
	output logic      [N_ENG-1:0]  instr_ready,
	input  wire logic [7:0]        var_a [N_ENG],
	input  wire logic [7:0]        var_b [N_ENG],
	input  wire logic [7:0]        var_c [N_ENG],
	input  wire logic [7:0]        led_test_adc,
	input  wire logic [N_OUT-1:0]  map_row [N_ENG],
	output logic      [7:0]        eng_pwm [N_ENG],
	output logic      [6:0]        map_start_define [N_ENG],
	output logic      [6:0]        map_end_define [N_ENG],
	output logic      [N_DRV-1:0]  led_pwm_pin,
	output logic                   general_output_pin
);

	localparam int unsigned TDIV_W = $clog2(TICK_DIV + 1);

	initial begin
		if (N_ENG < 1 || N_ENG > 8) $error("lepw_engine supports one to eight engines");
		if (TICK_DIV < 1) $error("lepw_engine needs TICK_DIV of at least one");
	end

	// Decoding of the opcode field, used by the executor only.
	function automatic logic [3:0] op_of(input logic [WORD_W-1:0] w);
		op_of = w[OP_MSB:OP_LSB];
	endfunction : op_of

	// Source choice for a variable set-PWM; D is already resolved to register or ADC.
	function automatic logic [7:0] var_pick(input logic [1:0] sel, input logic [7:0] a,
			input logic [7:0] b, input logic [7:0] c, input logic [7:0] d);
		unique case (sel)
			VAR_SEL_A: var_pick = a;
			VAR_SEL_B: var_pick = b;
			VAR_SEL_C: var_pick = c;
			default:   var_pick = d;
		endcase
	endfunction : var_pick

	// Master tick generator.
	logic [TDIV_W-1:0] tdiv_q;
	logic [TDIV_W-1:0] tdiv_d;
	logic              tick;

	// One pulse per master period; everything in the engines counts these.
	always_comb begin
		tick   = (tdiv_q == TDIV_W'(TICK_DIV - 1));
		tdiv_d = tick ? '0 : tdiv_q + 1'b1;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tdiv_q <= '0;
		end else begin
			tdiv_q <= tdiv_d;
		end
	end

	// Host registers.
	logic [1:0]  ctrl_q;
	logic [1:0]  ctrl_d;
	logic [7:0]  var_d_q;
	logic [7:0]  var_d_d;
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic [7:0]  d_value;

	// Engine state.
	lepw_state_t      st_q  [N_ENG];
	lepw_state_t      st_d  [N_ENG];
	logic [CNT_W-1:0] cnt_q [N_ENG];
	logic [CNT_W-1:0] cnt_d [N_ENG];
	logic [7:0]       pwm_q [N_ENG];
	logic [7:0]       pwm_d [N_ENG];
	logic [6:0]       ms_q  [N_ENG];
	logic [6:0]       ms_d  [N_ENG];
	logic [6:0]       me_q  [N_ENG];
	logic [6:0]       me_d  [N_ENG];

	assign d_value = ctrl_q[CTRL_D_ADC] ? led_test_adc : var_d_q;

	// A word is taken only while its engine is idle, so the memory simply holds it.
	always_comb begin
		for (int e = 0; e < N_ENG; e++) begin
			instr_ready[e] = (st_q[e] == ST_IDLE);
		end
	end

	// Engine executor: the countdown ends execution, a taken word starts the next one.
	always_comb begin
		logic [WORD_W-1:0] w;
		logic [4:0]        wt;
		w  = '0;
		wt = '0;
		for (int e = 0; e < N_ENG; e++) begin
			st_d[e]  = st_q[e];
			cnt_d[e] = cnt_q[e];
			pwm_d[e] = pwm_q[e];
			ms_d[e]  = ms_q[e];
			me_d[e]  = me_q[e];
			if (st_q[e] != ST_IDLE && tick) begin
				if (cnt_q[e] <= CNT_W'(1)) begin
					st_d[e]  = ST_IDLE;
					cnt_d[e] = '0;
				end else begin
					cnt_d[e] = cnt_q[e] - 1'b1;
				end
			end
			if (instr_valid[e] && st_q[e] == ST_IDLE) begin
				w  = instr_data[e];
				wt = (w[WAIT_TIME_MSB:0] == 5'h00) ? 5'h01 : w[WAIT_TIME_MSB:0];
				unique case (op_of(w))
					OP_SET_PWM_IMM: begin
						pwm_d[e] = w[7:0];
						st_d[e]  = ST_EXEC;
						cnt_d[e] = CNT_W'(EXEC_TICKS);
					end
					OP_SET_PWM_VAR: begin
						pwm_d[e] = var_pick(w[VAR_SEL_MSB:0], var_a[e], var_b[e], var_c[e], d_value);
						st_d[e]  = ST_EXEC;
						cnt_d[e] = CNT_W'(EXEC_TICKS);
					end
					OP_WAIT: begin
						st_d[e]  = ST_WAIT;
						// Time zero is out of range and is stretched to one step.
						cnt_d[e] = CNT_W'(wt) * (w[WAIT_PRE_BIT] ? CNT_W'(WAIT_DIV_SLOW)
							: CNT_W'(WAIT_DIV_FAST));
					end
					OP_MAP_START: begin
						// Only the address is kept; rows and connections are left alone.
						if (w[ADDR_MSB:0] <= MAP_ADDR_MAX) begin
							ms_d[e] = w[ADDR_MSB:0];
						end
						st_d[e]  = ST_EXEC;
						cnt_d[e] = CNT_W'(EXEC_TICKS);
					end
					OP_MAP_END: begin
						if (w[ADDR_MSB:0] <= MAP_ADDR_MAX) begin
							me_d[e] = w[ADDR_MSB:0];
						end
						st_d[e]  = ST_EXEC;
						cnt_d[e] = CNT_W'(EXEC_TICKS);
					end
					default: begin
						// Other opcodes belong to other units; the word is consumed here without effect.
						st_d[e] = ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int e = 0; e < N_ENG; e++) begin
				st_q[e]  <= ST_IDLE;
				cnt_q[e] <= '0;
				pwm_q[e] <= '0;
				ms_q[e]  <= '0;
				me_q[e]  <= '0;
			end
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			pwm_q <= pwm_d;
			ms_q  <= ms_d;
			me_q  <= me_d;
		end
	end

	// Engine values and table limits leave straight from their flip-flops.
	always_comb begin
		for (int e = 0; e < N_ENG; e++) begin
			eng_pwm[e]          = pwm_q[e];
			map_start_define[e] = ms_q[e];
			map_end_define[e]   = me_q[e];
		end
	end

	// Output multiplexer.
	logic [7:0]       lvl     [N_OUT];
	logic [N_OUT-1:0] mapped;
	logic [N_OUT-1:0] pin_raw;
	logic             gpo_q;
	logic             gpo_d;

	// Lowest engine number wins when the table maps two engines onto one output.
	always_comb begin
		for (int i = 0; i < N_OUT; i++) begin
			lvl[i]    = '0;
			mapped[i] = 1'b0;
			for (int e = N_ENG - 1; e >= 0; e--) begin
				if (map_row[e][i]) begin
					lvl[i]    = pwm_q[e];
					mapped[i] = 1'b1;
				end
			end
		end
	end

	// One duty generator per output, the general pin included.
	genvar gi;
	generate
		for (gi = 0; gi < N_OUT; gi++) begin : g_pwm
			lepw_pwm #(
				.WIDTH   (8)
			) u_pwm (
				.ref_clk (ref_clk),
				.resetn  (resetn),
				.duty    (lvl[gi]),
				.pwm_out (pin_raw[gi])
			);
		end
	endgenerate

	// An unmapped driver is dark; an unmapped general pin falls back to host control.
	always_comb begin
		gpo_d = mapped[N_DRV] ? pin_raw[N_DRV] : ctrl_q[CTRL_GPO];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gpo_q <= 1'b0;
		end else begin
			gpo_q <= gpo_d;
		end
	end

	assign led_pwm_pin        = pin_raw[N_DRV-1:0];
	assign general_output_pin = gpo_q;

	// Wishbone slave: decode, write strobe on lane 0, read data registered with ack.
	logic [6:0]  idx;
	logic        req;
	logic        wr;
	logic [31:0] status;

	assign idx = wb_adr_i[8:2];
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr  = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];  // Lands on the edge that samples ack.

	// Busy engines in the low byte, waiting engines in the next.
	always_comb begin
		status = '0;
		for (int e = 0; e < N_ENG; e++) begin
			status[e]     = (st_q[e] != ST_IDLE);
			status[8 + e] = (st_q[e] == ST_WAIT);
		end
	end

	// Unmapped indices read zero and still answer, so the bus never hangs.
	always_comb begin
		ctrl_d  = ctrl_q;
		var_d_d = var_d_q;
		ack_d   = req;
		rdat_d  = rdat_q;
		if (wr && idx == REG_CTRL) begin
			ctrl_d = wb_dat_i[1:0];
		end
		if (wr && idx == REG_VAR_D) begin
			var_d_d = wb_dat_i[7:0];
		end
		if (req) begin
			rdat_d = '0;
			if (idx == REG_CTRL) begin
				rdat_d = {30'h0, ctrl_q};
			end else if (idx == REG_STATUS) begin
				rdat_d = status;
			end else if (idx == REG_VAR_D) begin
				rdat_d = {24'h0, var_d_q};
			end else if (idx == REG_ADC) begin
				rdat_d = {24'h0, led_test_adc};
			end else begin
				for (int e = 0; e < N_ENG; e++) begin
					if (idx == REG_PWM_BASE + 7'(e)) begin
						rdat_d = {24'h0, pwm_q[e]};
					end
					if (idx == REG_MAP_BASE + 7'(e)) begin
						rdat_d = {17'h0, me_q[e], 1'b0, ms_q[e]};
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q  <= CTRL_RST;
			var_d_q <= VAR_D_RST;
			ack_q   <= 1'b0;
			rdat_q  <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			var_d_q <= var_d_d;
			ack_q   <= ack_d;
			rdat_q  <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

endmodule : lepw_engine

// *** hdl/lepw_pkg.sv ***
// Purpose: Shared constants for the LED engine set-PWM, wait and map setup decoder.
// Assumes: 20 MHz system clock; the engine time base is a 32 768 Hz tick derived from it.
// Notes:   Opcode encoding is local to this design and matches a 16-bit program word.
package lepw_pkg;

	// Clock and engine time base.
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned MASTER_HZ     = 32_768;
	localparam int unsigned MASTER_DIV    = CLK_HZ / MASTER_HZ;  // 610 system cycles per master tick.
	localparam int unsigned EXEC_TICKS    = 16;                  // Set-PWM and setup execution time.
	localparam int unsigned WAIT_DIV_FAST = 16;                  // Prescale 0: 0.488 ms per step.
	localparam int unsigned WAIT_DIV_SLOW = 512;                 // Prescale 1: 15.625 ms per step.
	localparam int unsigned CNT_W         = 14;                  // Holds 31 * 512 ticks.

	// Program word layout.
	localparam int unsigned WORD_W        = 16;
	localparam int unsigned OP_MSB        = 15;
	localparam int unsigned OP_LSB        = 12;
	localparam int unsigned WAIT_PRE_BIT  = 5;
	localparam int unsigned WAIT_TIME_MSB = 4;
	localparam int unsigned ADDR_MSB      = 6;
	localparam int unsigned VAR_SEL_MSB   = 1;

	// Opcodes.
	localparam logic [3:0] OP_SET_PWM_IMM = 4'h4;
	localparam logic [3:0] OP_SET_PWM_VAR = 4'h8;
	localparam logic [3:0] OP_WAIT        = 4'h2;
	localparam logic [3:0] OP_MAP_START   = 4'h9;
	localparam logic [3:0] OP_MAP_END     = 4'hA;

	// Variable selector codes.
	localparam logic [1:0] VAR_SEL_A = 2'h0;
	localparam logic [1:0] VAR_SEL_B = 2'h1;
	localparam logic [1:0] VAR_SEL_C = 2'h2;

	// Mapping table limits and outputs.
	localparam logic [6:0]  MAP_ADDR_MAX = 7'h5F;  // Address 95.
	localparam int unsigned N_DRV        = 9;
	localparam int unsigned N_OUT        = 10;     // Nine drivers plus the general output pin.

	// Register indices; byte address is four times the index.
	localparam logic [6:0] REG_CTRL     = 7'h00;
	localparam logic [6:0] REG_STATUS   = 7'h01;
	localparam logic [6:0] REG_PWM_BASE = 7'h10;
	localparam logic [6:0] REG_MAP_BASE = 7'h18;
	localparam logic [6:0] REG_VAR_D    = 7'h3C;
	localparam logic [6:0] REG_ADC      = 7'h42;

	// Control fields and reset values.
	localparam int unsigned CTRL_D_ADC = 0;
	localparam int unsigned CTRL_GPO   = 1;
	localparam logic [1:0]  CTRL_RST   = 2'h0;
	localparam logic [7:0]  VAR_D_RST  = 8'h00;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_WAIT = 2'b10
	} lepw_state_t;

endpackage : lepw_pkg

// *** hdl/lepw_pwm.sv ***
// Purpose: Eight-bit duty cycle generator for one output.
// Assumes: Duty changes may land mid-period; the next compare uses the new value.
// Notes:   Period is 255 system cycles so that 255 is a true 100 percent.
`timescale 1ns/10ps
module lepw_pwm
	import lepw_pkg::*;
#(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] duty,
	output logic                  pwm_out
);

	localparam logic [WIDTH-1:0] CNT_TOP = {{(WIDTH-1){1'b1}}, 1'b0};

	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;
	logic             out_d;

	initial begin
		if (WIDTH < 2) $error("lepw_pwm needs WIDTH of at least 2");
	end

	// Counter runs 0..max-1 so duty 0 never fires and full scale never drops.
	always_comb begin
		cnt_d = (cnt_q == CNT_TOP) ? '0 : cnt_q + 1'b1;
		out_d = (cnt_d < duty);
	end

	// Output is registered so the pin never glitches on a duty change.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q   <= '0;
			pwm_out <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			pwm_out <= out_d;
		end
	end

endmodule : lepw_pwm

// *** tb/lepw_engine_asserts.sv ***
// Purpose: Port-level checks of the set-PWM, wait and map setup decoder.
// Assumes: Engine 0 carries the instruction traffic that is checked.
// Notes:   Bound into every lepw_engine instance.
`timescale 1ns/10ps
module lepw_engine_asserts
	import lepw_pkg::*;
#(
	parameter int unsigned N_ENG    = 3,
	parameter int unsigned TICK_DIV = MASTER_DIV
) (
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_ack_o,
	input wire logic [N_ENG-1:0]  instr_valid,
	input wire logic [WORD_W-1:0] instr_data [N_ENG],
	input wire logic [N_ENG-1:0]  instr_ready,
	input wire logic [7:0]        var_a [N_ENG],
	input wire logic [7:0]        var_b [N_ENG],
	input wire logic [7:0]        var_c [N_ENG],
	input wire logic [7:0]        eng_pwm [N_ENG],
	input wire logic [6:0]        map_start_define [N_ENG],
	input wire logic [6:0]        map_end_define [N_ENG]
);
	logic       take0;
	logic [3:0] op0;
	logic [4:0] tm0;
	logic [7:0] sel_v;
	logic       wt_q, wt_d;
	int         busy_q, busy_d, ticks_q, ticks_d;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	assign take0 = instr_valid[0] && instr_ready[0];
	assign op0   = instr_data[0][OP_MSB:OP_LSB];
	assign tm0   = instr_data[0][WAIT_TIME_MSB:0];
	// Tracks the wait state and busy length so timing is judged by counted cycles.
	always_comb begin
		sel_v   = (instr_data[0][1:0] == VAR_SEL_A) ? var_a[0] : (instr_data[0][1:0] == VAR_SEL_B) ? var_b[0] : var_c[0];
		wt_d    = (take0 && op0 == OP_WAIT) ? 1'b1 : (instr_ready[0] ? 1'b0 : wt_q);
		busy_d  = take0 ? 0 : (instr_ready[0] ? busy_q : busy_q + 1);
		ticks_d = ticks_q;
		if (take0) begin
			ticks_d = (op0 != OP_WAIT) ? 16 : (instr_data[0][WAIT_PRE_BIT] ? 512 : 16) * ((tm0 == 5'h00) ? 1 : int'(tm0));
		end
	end
	// Registers the helper state.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wt_q    <= 1'b0;
			busy_q  <= 0;
			ticks_q <= 16;
		end else begin
			wt_q    <= wt_d;
			busy_q  <= busy_d;
			ticks_q <= ticks_d;
		end
	end

	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
	AST_IMM_LOAD: assert property (take0 && op0 == OP_SET_PWM_IMM |=> eng_pwm[0] == $past(instr_data[0][7:0]) && !instr_ready[0])
		else $error("immediate value not loaded");
	AST_VAR_LOAD: assert property (take0 && op0 == OP_SET_PWM_VAR && instr_data[0][1:0] != 2'h3 |=> eng_pwm[0] == $past(sel_v))
		else $error("variable value not loaded");
	AST_EXEC_TIME: assert property ($rose(instr_ready[0]) |-> busy_q >= (ticks_q - 1) * TICK_DIV - 1 && busy_q <= ticks_q * TICK_DIV + 1)
		else $error("execution length wrong");
	AST_WAIT_FREEZE: assert property (wt_q |-> $stable(eng_pwm[0])) else $error("value moved during wait");
	AST_MAP_START: assert property (take0 && op0 == OP_MAP_START && instr_data[0][6:0] <= MAP_ADDR_MAX
		|=> map_start_define[0] == $past(instr_data[0][6:0]) && $stable(map_end_define[0])) else $error("start address wrong");
	AST_MAP_END: assert property (take0 && op0 == OP_MAP_END && instr_data[0][6:0] <= MAP_ADDR_MAX
		|=> map_end_define[0] == $past(instr_data[0][6:0])) else $error("end address wrong");
	AST_MAP_RANGE: assert property (take0 && op0 == OP_MAP_START && instr_data[0][6:0] > MAP_ADDR_MAX
		|=> $stable(map_start_define[0])) else $error("bad start address stored");
	COV_WAIT_SLOW: cover property (take0 && op0 == OP_WAIT && instr_data[0][WAIT_PRE_BIT]);
	COV_VAR: cover property (take0 && op0 == OP_SET_PWM_VAR);
	COV_MAP_END: cover property (take0 && op0 == OP_MAP_END);
endmodule : lepw_engine_asserts

bind lepw_engine lepw_engine_asserts #(.N_ENG(N_ENG), .TICK_DIV(TICK_DIV)) i_lepw_engine_asserts (.ref_clk(ref_clk),
	.resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .instr_valid(instr_valid),
	.instr_data(instr_data), .instr_ready(instr_ready), .var_a(var_a), .var_b(var_b), .var_c(var_c), .eng_pwm(eng_pwm),
	.map_start_define(map_start_define), .map_end_define(map_end_define));

// *** tb/lepw_prog_mem.sv ***
// Purpose: Program memory model that hands words to the engines.
// Assumes: Called right after a rising edge.
// Notes:   A released word line shows the inverse of its last word.
`timescale 1ns/10ps
module lepw_prog_mem
	import lepw_pkg::*;
#(
	parameter int unsigned N_ENG = 3
) (
	input  wire logic              ref_clk,
	input  wire logic [N_ENG-1:0]  instr_ready,
	output logic      [N_ENG-1:0]  instr_valid,
	output logic      [WORD_W-1:0] instr_data [N_ENG]
);
	// Nothing is offered before the bench asks.
	initial begin
		instr_valid = '0;
		for (int i = 0; i < N_ENG; i++) begin
			instr_data[i] = 16'hFFFF;
		end
	end

	// Holds the word until the edge that samples ready high; ok stays low on a timeout.
	task automatic send(input int e, input logic [WORD_W-1:0] w, output bit ok);
		ok = 1'b0;
		instr_valid[e] <= 1'b1;
		instr_data[e]  <= w;
		for (int n = 0; n < 5000 && !ok; n++) begin
			@(posedge ref_clk);
			ok = instr_ready[e];
		end
		instr_valid[e] <= 1'b0;
		instr_data[e]  <= ~w;
	endtask : send
endmodule : lepw_prog_mem

// *** tb/test_led_engine_pwm_wait_map_setup.sv ***
// Purpose: Self-checking bench of the set-PWM, wait and map setup decoder.
// Assumes: TICK_DIV of 2 shortens the master tick.
// Notes:   Variables come from a fixed seed.
`timescale 1ns/10ps
module test_led_engine_pwm_wait_map_setup;
	import lepw_pkg::*;
	localparam int unsigned TD = 2;
	logic              ref_clk = 1'b0;
	logic              resetn = 1'b0;
	logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [8:0]        wb_adr_i = 9'h000;
	logic [3:0]        wb_sel_i = 4'hF;
	logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, rd;
	logic              wb_ack_o, general_output_pin;
	logic [2:0]        instr_valid, instr_ready;
	logic [WORD_W-1:0] instr_data [3];
	logic [7:0]        var_a [3], var_b [3], var_c [3], eng_pwm [3], v, d_val, led_test_adc;
	logic [N_OUT-1:0]  map_row [3];
	logic [6:0]        map_start_define [3], map_end_define [3];
	logic [N_DRV-1:0]  led_pwm_pin;
	int                mismatches = 0, cmp_count = 0, n, c[5];
	bit                ok;

	always #25 ref_clk = ~ref_clk;

	lepw_engine #(.TICK_DIV(TD)) i_lepw_engine (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid(instr_valid), .instr_data(instr_data),
		.instr_ready(instr_ready), .var_a(var_a), .var_b(var_b), .var_c(var_c), .led_test_adc(led_test_adc),
		.map_row(map_row), .eng_pwm(eng_pwm), .map_start_define(map_start_define), .map_end_define(map_end_define),
		.led_pwm_pin(led_pwm_pin), .general_output_pin(general_output_pin));
	lepw_prog_mem i_lepw_prog_mem (.ref_clk(ref_clk), .instr_ready(instr_ready), .instr_valid(instr_valid),
		.instr_data(instr_data));

	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One classic cycle: held until ack is sampled, then released for a cycle.
	task automatic wb(input logic we, input logic [6:0] idx, input logic [7:0] wd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			mismatches++;
			end_of_test();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask : wb

	// Sends a word and checks that the engine is busy for about t master ticks.
	task automatic run(input int e, input logic [15:0] w, input int t);
		i_lepw_prog_mem.send(e, w, ok);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (instr_ready[e] !== 1'b1 && n < 40000);
		if (!ok || n == 40000) begin
			mismatches++;
			end_of_test();
		end
		chk(n >= (t - 1) * TD && n <= t * TD + 2, 1);
	endtask : run

	function automatic logic [7:0] exp_var(input logic [1:0] sel, input logic adc);
		case (sel)
			2'h0: return var_a[0];
			2'h1: return var_b[0];
			2'h2: return var_c[0];
			default: return adc ? led_test_adc : d_val;
		endcase
	endfunction : exp_var

	// A hang ends in the closing report.
	initial begin
		repeat (100000) @(posedge ref_clk);
		mismatches++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'hC848));
		for (int i = 0; i < 3; i++) begin
			var_a[i]   <= $urandom;
			var_b[i]   <= $urandom;
			var_c[i]   <= $urandom;
			map_row[i] <= 10'h000;
		end
		led_test_adc <= $urandom;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		wb(1'b0, REG_CTRL, 8'h00);
		chk(rd, 32'h0);
		wb(1'b0, REG_VAR_D, 8'h00);
		chk(rd, {24'h0, VAR_D_RST});
		d_val = $urandom;
		wb(1'b1, REG_VAR_D, d_val);
		wb(1'b0, REG_VAR_D, 8'h00);
		chk(rd, {24'h0, d_val});
		wb(1'b0, 7'h7F, 8'h00);
		chk(rd, 32'h0);
		wb(1'b0, REG_ADC, 8'h00);
		chk(rd, {24'h0, led_test_adc});
		// With no engine mapped, the general pin follows the host level one flop later.
		wb(1'b1, REG_CTRL, 8'h02);
		@(posedge ref_clk);
		chk(general_output_pin, 1'b1);
		wb(1'b0, REG_CTRL, 8'h00);
		chk(rd, 32'h2);
		$display("Register test done");
		// Range ends first, then random values, back to back.
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			run(0, {OP_SET_PWM_IMM, 4'h0, v}, 16);
			chk(eng_pwm[0], v);
			wb(1'b0, REG_PWM_BASE, 8'h00);
			chk(rd, {24'h0, v});
		end
		// Every selector, and D from both of its sources.
		for (int k = 0; k < 5; k++) begin
			wb(1'b1, REG_CTRL, {7'h00, k == 4});
			run(0, {OP_SET_PWM_VAR, 10'h000, 2'(k > 3 ? 3 : k)}, 16);
			chk(eng_pwm[0], exp_var(2'(k > 3 ? 3 : k), k == 4));
		end
		$display("Set value test done");
		v = eng_pwm[0];
		run(0, {OP_WAIT, 6'h00, 1'b0, 5'h03}, 48);
		chk(eng_pwm[0], v);
		run(0, {OP_WAIT, 6'h00, 1'b1, 5'h01}, 512);
		run(0, {OP_WAIT, 6'h00, 1'b0, 5'h1F}, 496);
		// Status is read while engine 0 still waits; the next send waits for ready.
		i_lepw_prog_mem.send(0, {OP_WAIT, 6'h00, 1'b0, 5'h02}, ok);
		wb(1'b0, REG_STATUS, 8'h00);
		chk(rd, 32'h00000101);
		$display("Wait test done");
		run(0, {OP_MAP_START, 5'h00, 7'h50}, 16);
		chk(map_start_define[0], 7'h50);
		chk(map_end_define[0], 7'h00);
		run(0, {OP_MAP_END, 5'h00, 7'h5F}, 16);
		run(0, {OP_MAP_START, 5'h00, 7'h60}, 16);
		wb(1'b0, REG_MAP_BASE, 8'h00);
		chk(rd, {17'h0, 7'h5F, 1'b0, 7'h50});
		$display("Map setup test done");
		// Engine 0 drives driver 0 and the general pin, engine 1 drivers 1 and 2.
		map_row[0] <= 10'h201;
		map_row[1] <= 10'h006;
		run(0, {OP_SET_PWM_IMM, 4'h0, 8'h40}, 16);
		run(1, {OP_SET_PWM_IMM, 4'h0, 8'hFF}, 16);
		c = '{default: 0};
		repeat (255) begin
			@(posedge ref_clk);
			for (int i = 0; i < 4; i++) c[i] += led_pwm_pin[i];
			c[4] += general_output_pin;
		end
		chk(c[0], 32'h40);
		chk(c[1] + c[2], 32'h1FE);
		chk(c[3], 32'h0);
		chk(c[4], 32'h40);
		$display("Output test done");
		end_of_test();
	end
endmodule : test_led_engine_pwm_wait_map_setup
